/* File: rtl/rac_reset_interrupt.sv */
// Reset sequencer and interrupt prioritiser
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

// Operation
// - Any reset loads the reset vector and sets the mask.
// - Pin low 1.5 cycles resets; resume the cycle after release; the code resumes four cycles after it first samples the pin high.
// - Power-up waits the settle delay, then while pin is low.
// - Fetch outside RAM, EEPROM or ROM resets at once.
// - Watchdog reset keeps the operating mode.
// - Watchdog reset is a build option.
// - Undervoltage reset drives the reset pin low.
// - Nine maskable requests plus the trap.
// - Option bit 3 picks edge or edge-and-level external request.
// - Interrupt entry stacks registers then sets the mask.
// - Return from trap restores the stacked mask.
// - At instruction end, taken if unmasked and enabled.
// - Power-on or pin reset clears enables.
// - Highest priority pending goes first.
// - Trap ignores mask, follows requests pending at fetch; FFFC.
// - Latch clears on service; later pulse stays latched.
// - Realtime flag sets after the set count.
// - Tick overflow flag sets on wrap; shares FFF8 with realtime.
// - Vectors FFFA, FFF8, FFF6, FFF4, FFF2, FFF0 by source.
// - Divider runs in stop; periodic event wakes stop.
// - Periodic event also wakes from wait.
// - Mask holds off all maskable requests; clearing releases them.
// - Periodic flag sets on 14-bit wrap, clears by writing zero.
module rac_reset_interrupt #(
    parameter int unsigned POWERUP_SETTLE_CYCLES = 4096,
    parameter bit          WATCHDOG_PRESENT      = 1'b1
) (
    // Clock and power-on reset
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    // Pins and detectors
    input  wire logic        i_ext_reset_pin,
    output logic             o_ext_reset_pin_out,
    output logic             o_ext_reset_pin_oe,
    input  wire logic        i_irq_pin_n,
    input  wire logic        i_lv_reset,
    input  wire logic        i_lv_warn,
    input  wire logic        i_osc32,
    input  wire logic        i_mode_strap,
    // Core side
    input  wire logic        i_opcode_fetch,
    input  wire logic [15:0] i_fetch_addr,
    input  wire logic        i_instr_done,
    input  wire logic        i_trap_fetch,
    input  wire logic        i_return_trap,
    input  wire logic        i_stacked_imask,
    input  wire logic        i_imask_set,
    input  wire logic        i_imask_clear,
    input  wire logic        i_stop_mode,
    input  wire logic        i_wait_mode,
    input  wire logic        i_watchdog_timeout,
    output logic             o_core_reset,
    output logic             o_load_reset_vector,
    output logic             o_take_interrupt,
    output logic             o_push_regs,
    output logic [15:0]      o_vector_hi_addr,
    output logic [15:0]      o_vector_lo_addr,
    output logic             o_imask,
    output logic             o_wake,
    output logic             o_op_mode,
    // Peripheral request flags
    input  wire logic        i_keypad_strobe_flag,
    input  wire logic        i_timer16_flag,
    input  wire logic        i_sync_serial_flag,
    input  wire logic        i_async_serial_flag,
    // Register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic [7:0]       o_reg_rdata
);
    import rac_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [NUM_PIN-1:0] pin_raw;
    logic [NUM_PIN-1:0] pin_s1;
    logic [NUM_PIN-1:0] pin_s2;
    logic [NUM_PIN-1:0] pin_s3;
    logic [NUM_PIN-1:0] pin_stable;
    logic               stable_prev_irq;
    logic               stable_prev_osc;

    assign pin_raw = {i_mode_strap, i_osc32, i_lv_warn, i_lv_reset, i_irq_pin_n,
                      i_ext_reset_pin};

    // Counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PIN; gi++) begin : g_sync
            always_ff @(posedge i_core_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    pin_s1[gi]     <= PIN_IDLE[gi];
                    pin_s2[gi]     <= PIN_IDLE[gi];
                    pin_s3[gi]     <= PIN_IDLE[gi];
                    pin_stable[gi] <= PIN_IDLE[gi];
                end else begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi]) begin
                        pin_stable[gi] <= pin_s3[gi];
                    end
                end
            end
        end
    endgenerate

    wire ext_pin_high = pin_stable[0];
    wire irq_low      = ~pin_stable[1];
    wire lv_reset_act = pin_stable[2];
    wire lv_warn_act  = pin_stable[3];
    wire osc_rise     = pin_stable[4] & ~stable_prev_osc;
    wire irq_fall     = irq_low & stable_prev_irq;
    wire strap_level  = pin_stable[5];

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stable_prev_irq <= 1'b1;
            stable_prev_osc <= 1'b1;
        end else begin
            stable_prev_irq <= pin_stable[1];
            stable_prev_osc <= pin_stable[4];
        end
    end

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    rac_rst_state_type state;
    rac_rst_state_type next_state;
    logic [31:0]       settle_cnt;
    logic [3:0]        low_cnt;
    logic [3:0]        stretch_cnt;
    logic [4:0]        cause;

    wire fetch_legal = ((i_fetch_addr >= RAM_LO) && (i_fetch_addr <= RAM_HI))
                     || ((i_fetch_addr >= EE_LO) && (i_fetch_addr <= EE_HI))
                     || (i_fetch_addr >= ROM_LO);
    wire illegal_fetch = i_opcode_fetch & ~fetch_legal;
    wire wdog_reset    = WATCHDOG_PRESENT & i_watchdog_timeout;
    wire ext_reset_req = (low_cnt >= 4'(EXT_RST_MIN_CYC));
    wire pin_reset_req = ext_reset_req | lv_reset_act;
    wire int_reset_req = illegal_fetch | wdog_reset;
    wire in_run        = (state == RST_RUN);
    wire enter_pin_rst = in_run & pin_reset_req;
    wire leave_reset   = ~in_run & (next_state == RST_RUN);

    always_comb begin
        next_state = state;
        case (state)
            // settle then honour a held pin
            RST_SETTLE: begin
                if (settle_cnt >= POWERUP_SETTLE_CYCLES) begin
                    next_state = ext_pin_high ? RST_RUN : RST_HOLD;
                end
            end
            RST_HOLD: begin
                if (ext_pin_high && !lv_reset_act) begin
                    next_state = RST_RUN;
                end
            end
            RST_STRETCH: begin
                if (stretch_cnt == INT_RST_CYC) begin
                    next_state = RST_RUN;
                end
            end
            RST_RUN: begin
                if (pin_reset_req) begin
                    next_state = RST_HOLD;
                end else if (int_reset_req) begin
                    next_state = RST_STRETCH;
                end
            end
            default: next_state = RST_SETTLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state       <= RST_SETTLE;
            settle_cnt  <= 32'h0;
            low_cnt     <= 4'h0;
            stretch_cnt <= 4'h0;
            cause       <= 5'h01;
        end else begin
            state       <= next_state;
            settle_cnt  <= (state == RST_SETTLE) ? settle_cnt + 32'h1 : 32'h0;
            stretch_cnt <= (state == RST_STRETCH) ? stretch_cnt + 4'h1 : 4'h0;
            if (ext_pin_high) begin
                low_cnt <= 4'h0;
            end else if (!ext_reset_req) begin
                low_cnt <= low_cnt + 4'h1;
            end
            if (in_run && pin_reset_req) begin
                cause <= lv_reset_act ? 5'(1 << CAUSE_LV) : 5'(1 << CAUSE_EXT);
            end else if (in_run && int_reset_req) begin
                cause <= illegal_fetch ? 5'(1 << CAUSE_ILL) : 5'(1 << CAUSE_WDOG);
            end
        end
    end

    // drive the pin low during undervoltage
    assign o_ext_reset_pin_out = 1'b0;
    assign o_ext_reset_pin_oe  = lv_reset_act;
    assign o_core_reset        = ~in_run;

    // only power-on and pin resets resample the strap
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_op_mode <= 1'b0;
        end else if (leave_reset && (state != RST_STRETCH)) begin
            o_op_mode <= strap_level;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic       edge_level;
    logic       lv_en;
    logic       lv_flag;
    logic [1:0] rt_rate;
    logic       rt_en;
    logic       ovf_en;
    logic       rt_flag;
    logic       ovf_flag;
    logic       pw_en;
    logic       pw_flag;
    logic [3:0] periph_en;
    logic [7:0] tick_cnt;
    logic [7:0] tick_div;
    logic [3:0] ovf_cnt;
    logic [DIV_WIDTH-1:0] div32;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    wire wr_so   = i_reg_wr & hit(i_reg_addr, REG_SYS_OPT);
    wire wr_ct   = i_reg_wr & hit(i_reg_addr, REG_CORE_TICK);
    wire wr_pw   = i_reg_wr & hit(i_reg_addr, REG_PERIODIC);
    wire wr_pe   = i_reg_wr & hit(i_reg_addr, REG_PERIPH_EN);

    // Bus-clocked tick halts with the oscillator in stop
    wire tick_step  = ~i_stop_mode & (tick_div == TICK_DIV_CYC - 8'h1);
    // overflow on wrap from maximum to zero
    wire tick_wrap  = tick_step & (tick_cnt == 8'hff);
    wire rt_hit     = tick_wrap & (ovf_cnt == 4'((1 << rt_rate) - 1));
    wire div_wrap   = osc_rise & (&div32);

    // Set wins over a clearing write
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            edge_level <= 1'b0;
            lv_en      <= 1'b0;
            lv_flag    <= 1'b0;
            rt_rate    <= 2'h0;
            rt_en      <= 1'b0;
            ovf_en     <= 1'b0;
            rt_flag    <= 1'b0;
            ovf_flag   <= 1'b0;
            pw_en      <= 1'b0;
            pw_flag    <= 1'b0;
            periph_en  <= 4'h0;
        end else if (enter_pin_rst) begin
            lv_en     <= 1'b0;
            rt_en     <= 1'b0;
            ovf_en    <= 1'b0;
            pw_en     <= 1'b0;
            periph_en <= 4'h0;
        end else begin
            if (wr_so) begin
                edge_level <= i_reg_wdata[SO_EDGE_LEVEL];
                lv_en      <= i_reg_wdata[SO_LV_EN];
            end
            lv_flag <= lv_warn_act | (lv_flag & ~(wr_so & ~i_reg_wdata[SO_LV_FLAG]));
            if (wr_ct) begin
                rt_rate <= i_reg_wdata[CT_RT_RATE_LO +: 2];
                rt_en   <= i_reg_wdata[CT_RT_EN];
                ovf_en  <= i_reg_wdata[CT_OVF_EN];
            end
            rt_flag  <= rt_hit | (rt_flag & ~(wr_ct & ~i_reg_wdata[CT_RT_FLAG]));
            ovf_flag <= tick_wrap | (ovf_flag & ~(wr_ct & ~i_reg_wdata[CT_OVF_FLAG]));
            if (wr_pw) begin
                pw_en <= i_reg_wdata[PW_EN];
            end
            pw_flag <= div_wrap | (pw_flag & ~(wr_pw & ~i_reg_wdata[PW_FLAG]));
            if (wr_pe) begin
                periph_en <= i_reg_wdata[3:0];
            end
        end
    end

    // divider runs in stop and wait
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div32    <= '0;
            tick_div <= 8'h0;
            tick_cnt <= 8'h0;
            ovf_cnt  <= 4'h0;
        end else begin
            if (osc_rise) begin
                div32 <= div32 + 1'b1;
            end
            if (!i_stop_mode) begin
                tick_div <= tick_step ? 8'h0 : tick_div + 8'h1;
            end
            if (tick_step) begin
                tick_cnt <= tick_cnt + 8'h1;
            end
            if (rt_hit) begin
                ovf_cnt <= 4'h0;
            end else if (tick_wrap) begin
                ovf_cnt <= ovf_cnt + 4'h1;
            end
        end
    end

    // Read data stand one cycle only
    wire [7:0] rd_mux =
        hit(i_reg_addr, REG_SYS_OPT)   ? {4'h0, edge_level, 1'b0, lv_en, lv_flag} :
        hit(i_reg_addr, REG_CORE_TICK) ? {ovf_flag, rt_flag, ovf_en, rt_en, 2'h0, rt_rate} :
        hit(i_reg_addr, REG_PERIODIC)  ? {1'b0, pw_flag, 1'b0, pw_en, 4'h0} :
        hit(i_reg_addr, REG_PERIPH_EN) ? {4'h0, periph_en} :
        hit(i_reg_addr, REG_RST_STAT)  ? {1'b0, o_op_mode, 1'b0, cause} :
        hit(i_reg_addr, REG_TICK_CNT)  ? tick_cnt : 8'h00;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Requests and priority
    // ------------------------------------------------------------------
    logic               ext_latch;
    logic               trap_pending;
    logic               trap_snap;
    logic [NUM_SRC-1:0] req;

    wire ext_req = ext_latch | (edge_level & irq_low);
    // nine maskable sources folded onto six vectors
    assign req[0] = ext_req | (i_keypad_strobe_flag & periph_en[PE_KEYPAD]);
    assign req[1] = (ovf_flag & ovf_en) | (rt_flag & rt_en) | (pw_flag & pw_en);
    assign req[2] = i_timer16_flag & periph_en[PE_TMR16];
    assign req[3] = lv_flag & lv_en;
    assign req[4] = i_sync_serial_flag & periph_en[PE_SYNC];
    assign req[5] = i_async_serial_flag & periph_en[PE_ASYNC];

    function automatic logic [15:0] vector_of(input logic [NUM_SRC-1:0] r);
        if (r[0]) vector_of = VEC_EXT;
        else if (r[1]) vector_of = VEC_TICK;
        else if (r[2]) vector_of = VEC_TMR16;
        else if (r[3]) vector_of = VEC_LV;
        else if (r[4]) vector_of = VEC_SYNC;
        else vector_of = VEC_ASYNC;
    endfunction

    wire hw_ready  = (|req) & ~o_imask;
    // trap defers only to requests pending at its fetch
    wire take_hw   = in_run & i_instr_done & hw_ready & (~trap_pending | trap_snap);
    wire take_trap = in_run & i_instr_done & trap_pending & ~take_hw;
    wire ext_clear = take_hw & req[0] & ext_latch;
    wire [15:0] svc_vec = take_hw ? vector_of(req) : VEC_TRAP;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_latch    <= 1'b0;
            trap_pending <= 1'b0;
            trap_snap    <= 1'b0;
        end else if (!in_run) begin
            ext_latch    <= 1'b0;
            trap_pending <= 1'b0;
            trap_snap    <= 1'b0;
        end else begin
            ext_latch <= irq_fall | (ext_latch & ~ext_clear);
            if (i_trap_fetch) begin
                trap_pending <= 1'b1;
                trap_snap    <= hw_ready;
            end else if (take_trap) begin
                trap_pending <= 1'b0;
            end else if (take_hw) begin
                trap_snap <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Core handshake
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_imask             <= 1'b1;
            o_take_interrupt    <= 1'b0;
            o_push_regs         <= 1'b0;
            o_load_reset_vector <= 1'b0;
            o_vector_hi_addr    <= VEC_RESET;
            o_vector_lo_addr    <= VEC_RESET | 16'h0001;
            o_wake              <= 1'b0;
        end else begin
            o_take_interrupt    <= take_hw | take_trap;
            o_push_regs         <= take_hw | take_trap;
            o_load_reset_vector <= leave_reset;
            if (!in_run) begin
                o_imask          <= 1'b1;
                o_vector_hi_addr <= VEC_RESET;
                o_vector_lo_addr <= VEC_RESET | 16'h0001;
            end else if (take_hw || take_trap) begin
                o_imask <= 1'b1;
                o_vector_hi_addr <= svc_vec;
                o_vector_lo_addr <= svc_vec | 16'h0001;
            end else if (i_return_trap) begin
                o_imask <= i_stacked_imask;
            end else if (i_imask_set) begin
                o_imask <= 1'b1;
            end else if (i_imask_clear) begin
                o_imask <= 1'b0;
            end
            o_wake <= in_run & ((i_stop_mode & (req[0] | req[3] | (pw_flag & pw_en)))
                              | (i_wait_mode & (|req)));
        end
    end

endmodule // rac_reset_interrupt

/* File: rtl/rac_pkg.sv */
// Reset and interrupt controller constants
package rac_pkg;

    // ------------------------------------------------------------------
    // Vector addresses (even byte is high)
    // ------------------------------------------------------------------
    localparam logic [15:0] VEC_RESET   = 16'hfffe;
    localparam logic [15:0] VEC_TRAP    = 16'hfffc;
    localparam logic [15:0] VEC_EXT     = 16'hfffa;
    localparam logic [15:0] VEC_TICK    = 16'hfff8;
    localparam logic [15:0] VEC_TMR16   = 16'hfff6;
    localparam logic [15:0] VEC_LV      = 16'hfff4;
    localparam logic [15:0] VEC_SYNC    = 16'hfff2;
    localparam logic [15:0] VEC_ASYNC   = 16'hfff0;

    // ------------------------------------------------------------------
    // Legal opcode fetch space
    // ------------------------------------------------------------------
    localparam logic [15:0] RAM_LO      = 16'h0068;
    localparam logic [15:0] RAM_HI      = 16'h03ff;
    localparam logic [15:0] EE_LO       = 16'h0400;
    localparam logic [15:0] EE_HI       = 16'h04ff;
    localparam logic [15:0] ROM_LO      = 16'h8000;

    // ------------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_SYS_OPT   = 8'h00;
    localparam logic [7:0] REG_CORE_TICK = 8'h01;
    localparam logic [7:0] REG_PERIODIC  = 8'h02;
    localparam logic [7:0] REG_PERIPH_EN = 8'h03;
    localparam logic [7:0] REG_RST_STAT  = 8'h04;
    localparam logic [7:0] REG_TICK_CNT  = 8'h05;

    localparam int SO_LV_FLAG     = 0;
    localparam int SO_LV_EN       = 1;
    localparam int SO_EDGE_LEVEL  = 3;
    localparam int CT_RT_RATE_LO  = 0;
    localparam int CT_RT_EN       = 4;
    localparam int CT_OVF_EN      = 5;
    localparam int CT_RT_FLAG     = 6;
    localparam int CT_OVF_FLAG    = 7;
    localparam int PW_EN          = 4;
    localparam int PW_FLAG        = 6;
    localparam int PE_KEYPAD      = 0;
    localparam int PE_TMR16       = 1;
    localparam int PE_SYNC        = 2;
    localparam int PE_ASYNC       = 3;

    // ------------------------------------------------------------------
    // Timing and sizes
    // ------------------------------------------------------------------
    localparam int EXT_RST_MIN_HALF_CYC = 3;
    localparam int EXT_RST_MIN_CYC      = (EXT_RST_MIN_HALF_CYC + 1) / 2;
    localparam logic [3:0] INT_RST_CYC  = 4'h4;
    localparam logic [7:0] TICK_DIV_CYC = 8'h08;
    localparam int DIV_WIDTH            = 14;
    localparam int NUM_SRC              = 6;
    localparam int NUM_PIN              = 6;
    localparam logic [5:0] PIN_IDLE     = 6'h03;

    // One-hot cause bits of reset status
    localparam int CAUSE_POR   = 0;
    localparam int CAUSE_EXT   = 1;
    localparam int CAUSE_LV    = 2;
    localparam int CAUSE_ILL   = 3;
    localparam int CAUSE_WDOG  = 4;

    typedef enum {RST_SETTLE, RST_HOLD, RST_STRETCH, RST_RUN} rac_rst_state_type;

endpackage : rac_pkg

/* File: testbench/rac_asserts.sv */
// Reset and interrupt port checker
`timescale 1ns/1ps
module rac_asserts (
    input wire logic        i_core_clk, i_resetn, i_ext_reset_pin, i_lv_reset,
    input wire logic        i_opcode_fetch, i_instr_done, i_watchdog_timeout,
    input wire logic [15:0] i_fetch_addr, o_vector_hi_addr, o_vector_lo_addr,
    input wire logic        o_ext_reset_pin_out, o_ext_reset_pin_oe, o_core_reset,
    input wire logic        o_load_reset_vector, o_take_interrupt, o_push_regs,
    input wire logic        o_imask, o_op_mode
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    property p_rst_vec; $fell(o_core_reset) |-> o_load_reset_vector && o_imask; endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("reset vector not loaded");
    property p_pin; o_core_reset && $rose(i_ext_reset_pin) && !$past(o_ext_reset_pin_oe)
        |-> ##[1:8] !o_core_reset; endproperty
    a_pin: assert property (p_pin) else $error("pin release not resumed");
    property p_ill; i_opcode_fetch && !o_core_reset && (i_fetch_addr < 16'h0068 ||
        (i_fetch_addr > 16'h04ff && i_fetch_addr < 16'h8000))
        |=> o_core_reset [*4] ##[1:2] !o_core_reset; endproperty
    a_ill: assert property (p_ill) else $error("illegal fetch reset wrong");
    property p_wdog; i_watchdog_timeout && !o_core_reset
        |=> o_core_reset ##1 $stable(o_op_mode) [*4]; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog reset wrong");
    property p_lv; i_lv_reset [*6] |-> o_ext_reset_pin_oe && !o_ext_reset_pin_out; endproperty
    a_lv: assert property (p_lv) else $error("reset pin not driven low");
    property p_take; o_take_interrupt |-> o_push_regs && o_imask && $past(i_instr_done);
    endproperty
    a_take: assert property (p_take) else $error("bad interrupt entry");
    property p_mask; o_take_interrupt && $past(o_imask) |-> o_vector_hi_addr == 16'hfffc;
    endproperty
    a_mask: assert property (p_mask) else $error("masked request taken");
    property p_vec; o_take_interrupt |-> o_vector_hi_addr inside {16'hfffc, 16'hfffa,
        16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0}; endproperty
    a_vec: assert property (p_vec) else $error("unknown vector");
    property p_pair; o_vector_lo_addr == (o_vector_hi_addr | 16'h0001); endproperty
    a_pair: assert property (p_pair) else $error("vector byte pair wrong");
    c_trap: cover property (o_take_interrupt && o_vector_hi_addr == 16'hfffc);
    c_low: cover property (o_take_interrupt && o_vector_hi_addr == 16'hfff0);
    c_load: cover property (o_load_reset_vector);
endmodule // rac_asserts
bind rac_reset_interrupt rac_asserts chk_u (.*);

/* File: testbench/rac_core_model.sv */
// Core stand-in
`timescale 1ns/1ps
module rac_core_model (
    input  wire logic i_core_clk, i_resetn, i_take, i_slow,
    output logic      o_instr_done, o_return_trap
);
    int  cnt;
    logic svc;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= 0; svc <= 0; o_instr_done <= 0; o_return_trap <= 0;
        end else begin
            cnt <= (cnt >= (i_slow ? 11 : 3)) ? 0 : cnt + 1;
            o_instr_done <= (cnt == 0);
            svc <= i_take | (svc & (cnt != 2));
            o_return_trap <= svc && cnt == 2 && !i_take;
        end
    end
endmodule // rac_core_model

/* File: testbench/rac_reset_interrupt_bench.sv */
// Self-checking reset and interrupt bench
`timescale 1ns/1ps
module rac_reset_interrupt_bench;
    import rac_pkg::*;
    logic clk = 0, rstn = 0, pin = 1, lv = 0, osc = 0, fe = 0, trap = 0, wd = 0, wr = 0, rd = 0;
    logic slow = 0, z = 0, oe, cr, tk, im, done, ret;
    logic [2:0]  fl = 0;
    logic [7:0]  ra = 0, wdt = 0, rdata;
    logic [15:0] fa = 16'h8000, hi;
    logic [15:0] vt [3] = '{16'hfff6, 16'hfff2, 16'hfff0};
    int bad_count = 0, n_checks = 0, tick = 0, q[$];
    rac_reset_interrupt #(.POWERUP_SETTLE_CYCLES(16)) dut_u (.i_core_clk(clk), .i_resetn(rstn),
        .i_ext_reset_pin(oe ? 1'b0 : pin), .o_ext_reset_pin_out(), .o_ext_reset_pin_oe(oe),
        .i_irq_pin_n(!z), .i_lv_reset(lv), .i_lv_warn(z), .i_osc32(osc), .i_mode_strap(z),
        .i_opcode_fetch(fe), .i_fetch_addr(fa), .i_instr_done(done), .i_trap_fetch(trap),
        .i_return_trap(ret), .i_stacked_imask(z), .i_imask_set(z), .i_imask_clear(z),
        .i_stop_mode(z), .i_wait_mode(z), .i_watchdog_timeout(wd), .o_core_reset(cr),
        .o_load_reset_vector(), .o_take_interrupt(tk), .o_push_regs(), .o_vector_hi_addr(hi),
        .o_vector_lo_addr(), .o_imask(im), .o_wake(), .o_op_mode(), .i_keypad_strobe_flag(z),
        .i_timer16_flag(fl[0]), .i_sync_serial_flag(fl[1]), .i_async_serial_flag(fl[2]),
        .i_reg_addr(ra), .i_reg_wdata(wdt), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));
    rac_core_model core_u (.i_core_clk(clk), .i_resetn(rstn), .i_take(tk), .i_slow(slow),
        .o_instr_done(done), .o_return_trap(ret));
    // ------------------------------------------------------------------
    // Clock, oscillator, limit and tasks
    // ------------------------------------------------------------------
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        tick <= tick + 1;
        if (tick % 13 == 0) osc <= ~osc;
        if (tick > 20000) begin bad_count++; test_done; end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, e);
        n_checks++;
        if (s !== e) begin bad_count++; $display("MISMATCH %0t got %h want %h", $time, s, e); end
    endtask
    task automatic wreg(input logic [7:0] a, d);
        @(posedge clk) begin ra <= a; wdt <= d; wr <= 1; end
        @(posedge clk) wr <= 0;
    endtask
    task automatic rreg(input logic [7:0] a, e);
        @(posedge clk) begin ra <= a; rd <= 1; end
        @(posedge clk) rd <= 0;
        #1 chk({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic wtake(input logic [15:0] e);
        do begin @(posedge clk); #1; end while (tk !== 1'b1);
        chk(hi, e);
    endtask
    task automatic wrun;
        do begin @(posedge clk); #1; end while (cr !== 1'b0);
    endtask
    initial begin
        void'($urandom(22279));
        repeat (4) @(posedge clk);
        rstn <= 1;
        wrun;
        chk(im, 1);
        rreg(REG_RST_STAT, 8'h01);
        wreg(REG_PERIPH_EN, 8'h0e);
        rreg(REG_PERIPH_EN, 8'h0e);
        rreg(8'h3f, 8'h00);
        @(posedge clk) trap <= 1;
        @(posedge clk) trap <= 0;
        wtake(VEC_TRAP);
        $display("trap test done");
        for (int r = 0; r < 3; r++) begin
            @(posedge clk) begin fl <= 3'($urandom_range(7, 1)); slow <= r[0]; end
            #1 for (int b = 0; b < 3; b++) if (fl[b]) q.push_back(b);
            while (q.size() > 0) begin
                wtake(vt[q[0]]);
                fl[q.pop_front()] <= 1'b0;
            end
        end
        $display("priority test done");
        @(posedge clk) begin fe <= 1; fa <= EE_LO; end
        @(posedge clk) fe <= 0;
        repeat (3) @(posedge clk);
        #1 chk(cr, 0);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) begin fe <= (k == 0); fa <= 16'($urandom_range(103)); wd <= k[0]; end
            @(posedge clk) begin fe <= 0; wd <= 0; end
            wrun;
            rreg(REG_RST_STAT, k ? 8'h10 : 8'h08);
            rreg(REG_PERIPH_EN, 8'h0e);
        end
        $display("internal reset test done");
        @(posedge clk) pin <= 0;
        repeat (8) @(posedge clk);
        pin <= 1;
        wrun;
        rreg(REG_PERIPH_EN, 8'h00);
        rreg(REG_RST_STAT, 8'h02);
        @(posedge clk) lv <= 1;
        repeat (8) @(posedge clk);
        #1 chk(oe, 1);
        @(posedge clk) lv <= 0;
        wrun;
        rreg(REG_RST_STAT, 8'h04);
        $display("pin reset test done");
        test_done;
    end
endmodule // rac_reset_interrupt_bench
